// *** logic/amg_pkg.sv ***
/*
 Constants and carriers for the mode and pin configuration register bank.
 Assumes a register access port fed by the serial interface front end.
*/
package amg_pkg;
    // Register addresses
    localparam logic [7:0] ADDR_AVG = 8'h03;
    localparam logic [7:0] ADDR_MODE = 8'h04;
    localparam logic [7:0] ADDR_FUNC = 8'h05;
    localparam logic [7:0] ADDR_DIR = 8'h07;
    localparam logic [7:0] ADDR_DRV = 8'h09;
    localparam logic [7:0] ADDR_OUT = 8'h0b;
    localparam logic [7:0] ADDR_IN = 8'h0d;
    // Reset values
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] ALL_ANALOG = 8'h00;
    // Field layout
    localparam int AVG_MSB = 2;
    localparam int COE_BIT = 7;
    localparam int MODE_MSB = 6;
    localparam int MODE_LSB = 5;
    localparam int OSC_BIT = 4;
    localparam int DIV_MSB = 3;
    localparam logic [7:0] AVG_MASK = 8'h07;
    localparam logic [8:0] ONE_SAMPLE = 9'h001;

    // Conversion modes
    typedef enum logic [1:0] {
        AMG_MODE_MANUAL = 2'b00,
        AMG_MODE_AUTO = 2'b01
    } amg_mode_t;

    // Register access request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } amg_req_t;

    // Decoded settings toward the converter core
    typedef struct packed {
        logic [8:0] avg_count;
        logic auto_mode;
        logic manual_mode;
        logic osc_low_power;
        logic [3:0] clk_div;
        logic seq_pause;
    } amg_ctrl_t;
endpackage

// *** logic/amg_pin_cell.sv ***
/*
 One general-purpose pin driver cell.
 Assumes the pad resolves the wire from the enable; input already synchronised.
*/
`timescale 1ns/1ns
module amg_pin_cell (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Settings
    input wire logic gpio_sel,
    input wire logic dir_out,
    input wire logic push_pull,
    input wire logic level,
    // Pad
    output logic pad_out,
    output logic pad_oe
);
    logic next_out;
    logic next_oe;

    // Drive decision
    always_comb
    begin
        next_out = 1'b0;
        next_oe = 1'b0;
        if (gpio_sel && dir_out)
        begin
            next_out = level;
            next_oe = push_pull | ~level;
        end
    end

    // Register pad signals
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            pad_out <= 1'b0;
            pad_oe <= 1'b0;
        end
        else
        begin
            pad_out <= next_out;
            pad_oe <= next_oe;
        end
    end
endmodule

// *** logic/amg_regs.sv ***
/*
 Mode and pin configuration register bank with eight pin cells.
 Assumes a one-cycle register port from the serial front end and a crc error level.
*/
`timescale 1ns/1ns
module amg_regs (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Register port
    input wire amg_pkg::amg_req_t req,
    output logic [7:0] rdata,
    output logic rvalid,
    // Checksum error flag level
    input wire logic crc_err_in,
    // Converter control
    output amg_pkg::amg_ctrl_t ctrl,
    output logic [7:0] analog_sel,
    // Pads
    input wire logic [7:0] pad_in,
    output logic [7:0] pad_out,
    output logic [7:0] pad_oe
);
    logic [7:0] avg_cfg;
    logic [7:0] mode_cfg;
    logic [7:0] func_cfg;
    logic [7:0] dir_cfg;
    logic [7:0] drv_cfg;
    logic [7:0] out_cfg;
    logic [7:0] next_avg_cfg;
    logic [7:0] next_mode_cfg;
    logic [7:0] next_func_cfg;
    logic [7:0] next_dir_cfg;
    logic [7:0] next_drv_cfg;
    logic [7:0] next_out_cfg;
    logic [7:0] in_meta;
    logic [7:0] in_sync;
    logic [7:0] next_rdata;
    logic next_rvalid;
    amg_pkg::amg_ctrl_t next_ctrl;
    logic [7:0] next_analog_sel;
    logic [7:0] eff_func;
    logic err_hold;
    logic [1:0] mode_field;

    ////////////////////////////////////////////////////////////////////////
    // Register writes
    always_comb
    begin
        next_avg_cfg = avg_cfg;
        next_mode_cfg = mode_cfg;
        next_func_cfg = func_cfg;
        next_dir_cfg = dir_cfg;
        next_drv_cfg = drv_cfg;
        next_out_cfg = out_cfg;
        if (req.wr)
        begin
            if (req.addr == amg_pkg::ADDR_AVG)
                next_avg_cfg = req.wdata & amg_pkg::AVG_MASK;
            else if (req.addr == amg_pkg::ADDR_MODE)
                next_mode_cfg = req.wdata;
            else if (req.addr == amg_pkg::ADDR_FUNC)
                next_func_cfg = req.wdata;
            else if (req.addr == amg_pkg::ADDR_DIR)
                next_dir_cfg = req.wdata;
            else if (req.addr == amg_pkg::ADDR_DRV)
                next_drv_cfg = req.wdata;
            else if (req.addr == amg_pkg::ADDR_OUT)
                next_out_cfg = req.wdata;
        end
    end

    // Register storage
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            avg_cfg <= amg_pkg::REG_RESET;
            mode_cfg <= amg_pkg::REG_RESET;
            func_cfg <= amg_pkg::REG_RESET;
            dir_cfg <= amg_pkg::REG_RESET;
            drv_cfg <= amg_pkg::REG_RESET;
            out_cfg <= amg_pkg::REG_RESET;
        end
        else
        begin
            avg_cfg <= next_avg_cfg;
            mode_cfg <= next_mode_cfg;
            func_cfg <= next_func_cfg;
            dir_cfg <= next_dir_cfg;
            drv_cfg <= next_drv_cfg;
            out_cfg <= next_out_cfg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin input synchroniser
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            in_meta <= amg_pkg::REG_RESET;
            in_sync <= amg_pkg::REG_RESET;
        end
        else
        begin
            in_meta <= pad_in;
            in_sync <= in_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Error override of pin setup; stored registers keep their values
    assign err_hold = mode_cfg[amg_pkg::COE_BIT] & crc_err_in;
    assign eff_func = err_hold ? amg_pkg::ALL_ANALOG : func_cfg;
    assign mode_field = mode_cfg[amg_pkg::MODE_MSB:amg_pkg::MODE_LSB];

    // Decoded control and read data
    always_comb
    begin
        next_ctrl.avg_count = amg_pkg::ONE_SAMPLE << avg_cfg[amg_pkg::AVG_MSB:0];
        next_ctrl.manual_mode = (mode_field == amg_pkg::AMG_MODE_MANUAL);
        next_ctrl.auto_mode = (mode_field == amg_pkg::AMG_MODE_AUTO);
        next_ctrl.osc_low_power = mode_cfg[amg_pkg::OSC_BIT];
        next_ctrl.clk_div = mode_cfg[amg_pkg::DIV_MSB:0];
        next_ctrl.seq_pause = err_hold;
        next_analog_sel = ~eff_func;
        next_rvalid = req.rd;
        next_rdata = amg_pkg::REG_RESET;
        if (req.rd)
        begin
            if (req.addr == amg_pkg::ADDR_AVG)
                next_rdata = avg_cfg;
            else if (req.addr == amg_pkg::ADDR_MODE)
                next_rdata = mode_cfg;
            else if (req.addr == amg_pkg::ADDR_FUNC)
                next_rdata = func_cfg;
            else if (req.addr == amg_pkg::ADDR_DIR)
                next_rdata = dir_cfg;
            else if (req.addr == amg_pkg::ADDR_DRV)
                next_rdata = drv_cfg;
            else if (req.addr == amg_pkg::ADDR_OUT)
                next_rdata = out_cfg;
            else if (req.addr == amg_pkg::ADDR_IN)
                next_rdata = in_sync;
        end
    end

    // Output registers
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            ctrl <= '0;
            analog_sel <= amg_pkg::REG_RESET;
            rdata <= amg_pkg::REG_RESET;
            rvalid <= 1'b0;
        end
        else
        begin
            ctrl <= next_ctrl;
            analog_sel <= next_analog_sel;
            rdata <= next_rdata;
            rvalid <= next_rvalid;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin cells
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_pin
            amg_pin_cell u_cell (
                .clk(clk),
                .srst(srst),
                .gpio_sel(eff_func[gi]),
                .dir_out(dir_cfg[gi]),
                .push_pull(drv_cfg[gi]),
                .level(out_cfg[gi]),
                .pad_out(pad_out[gi]),
                .pad_oe(pad_oe[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Register access checks
    a_avg_upper_zero: assert property (@(posedge clk) disable iff (srst)
        (rvalid && $past(req.addr) == amg_pkg::ADDR_AVG) |-> (rdata & ~amg_pkg::AVG_MASK) == amg_pkg::REG_RESET)
        else $error("averaging upper bits not zero");
    a_avg_write_masked: assert property (@(posedge clk) disable iff (srst)
        (req.wr && req.addr == amg_pkg::ADDR_AVG) |=> avg_cfg == ($past(req.wdata) & amg_pkg::AVG_MASK))
        else $error("averaging write not masked");
    a_mode_write: assert property (@(posedge clk) disable iff (srst)
        (req.wr && req.addr == amg_pkg::ADDR_MODE) |=> mode_cfg == $past(req.wdata))
        else $error("mode write lost");
    a_func_write: assert property (@(posedge clk) disable iff (srst)
        (req.wr && req.addr == amg_pkg::ADDR_FUNC) |=> func_cfg == $past(req.wdata))
        else $error("function write lost");
    a_dir_write: assert property (@(posedge clk) disable iff (srst)
        (req.wr && req.addr == amg_pkg::ADDR_DIR) |=> dir_cfg == $past(req.wdata))
        else $error("direction write lost");
    a_drv_write: assert property (@(posedge clk) disable iff (srst)
        (req.wr && req.addr == amg_pkg::ADDR_DRV) |=> drv_cfg == $past(req.wdata))
        else $error("driver type write lost");
    a_out_write: assert property (@(posedge clk) disable iff (srst)
        (req.wr && req.addr == amg_pkg::ADDR_OUT) |=> out_cfg == $past(req.wdata))
        else $error("output level write lost");
    a_input_read_only: assert property (@(posedge clk) disable iff (srst)
        (req.wr && req.addr == amg_pkg::ADDR_IN) |=> (func_cfg == $past(func_cfg) && dir_cfg == $past(dir_cfg)
            && out_cfg == $past(out_cfg)))
        else $error("input level register took a write");
    a_input_level: assert property (@(posedge clk) disable iff (srst)
        (req.rd && req.addr == amg_pkg::ADDR_IN) |=> rdata == $past(in_sync))
        else $error("input level readback wrong");
    a_mode_readback: assert property (@(posedge clk) disable iff (srst)
        (req.rd && req.addr == amg_pkg::ADDR_MODE) |=> rdata == $past(mode_cfg))
        else $error("mode readback wrong");
    a_func_readback: assert property (@(posedge clk) disable iff (srst)
        (req.rd && req.addr == amg_pkg::ADDR_FUNC) |=> rdata == $past(func_cfg))
        else $error("function readback wrong");
    a_dir_readback: assert property (@(posedge clk) disable iff (srst)
        (req.rd && req.addr == amg_pkg::ADDR_DIR) |=> rdata == $past(dir_cfg))
        else $error("direction readback wrong");
    a_drv_readback: assert property (@(posedge clk) disable iff (srst)
        (req.rd && req.addr == amg_pkg::ADDR_DRV) |=> rdata == $past(drv_cfg))
        else $error("driver type readback wrong");
    a_out_readback: assert property (@(posedge clk) disable iff (srst)
        (req.rd && req.addr == amg_pkg::ADDR_OUT) |=> rdata == $past(out_cfg))
        else $error("output level readback wrong");
    a_reset_zero: assert property (@(posedge clk)
        srst |=> (mode_cfg == amg_pkg::REG_RESET && func_cfg == amg_pkg::REG_RESET && dir_cfg == amg_pkg::REG_RESET
            && drv_cfg == amg_pkg::REG_RESET && out_cfg == amg_pkg::REG_RESET))
        else $error("registers not zero after reset");

    ////////////////////////////////////////////////////////////////////////
    // Decoded control checks; skip the cycle still holding reset values
    a_avg_count: assert property (@(posedge clk) disable iff (srst)
        !$past(srst) |-> ctrl.avg_count == (amg_pkg::ONE_SAMPLE << $past(avg_cfg[amg_pkg::AVG_MSB:0])))
        else $error("averaging count wrong");
    a_mode_decode: assert property (@(posedge clk) disable iff (srst)
        !srst |=> (ctrl.auto_mode == ($past(mode_field) == amg_pkg::AMG_MODE_AUTO)
            && ctrl.manual_mode == ($past(mode_field) == amg_pkg::AMG_MODE_MANUAL)))
        else $error("mode decode wrong");
    a_osc_select: assert property (@(posedge clk) disable iff (srst)
        !srst |=> ctrl.osc_low_power == $past(mode_cfg[amg_pkg::OSC_BIT]))
        else $error("oscillator select wrong");
    a_div_field: assert property (@(posedge clk) disable iff (srst)
        !srst |=> ctrl.clk_div == $past(mode_cfg[amg_pkg::DIV_MSB:0]))
        else $error("divider field wrong");

    ////////////////////////////////////////////////////////////////////////
    // Checksum error checks
    a_err_forces_analog: assert property (@(posedge clk) disable iff (srst)
        (mode_cfg[amg_pkg::COE_BIT] && crc_err_in) |=> (analog_sel == ~amg_pkg::ALL_ANALOG && ctrl.seq_pause))
        else $error("error did not force analog");
    a_err_ignored: assert property (@(posedge clk) disable iff (srst)
        (!srst && !mode_cfg[amg_pkg::COE_BIT]) |=> (analog_sel == ~$past(func_cfg) && !ctrl.seq_pause))
        else $error("error disturbed pin setup");
    a_err_restore: assert property (@(posedge clk) disable iff (srst)
        ($fell(crc_err_in) && $stable(func_cfg)) |=> (analog_sel == ~$past(func_cfg) && !ctrl.seq_pause))
        else $error("pin setup not restored");
    a_err_keeps_setup: assert property (@(posedge clk) disable iff (srst)
        (err_hold && !(req.wr && req.addr == amg_pkg::ADDR_FUNC)) |=> func_cfg == $past(func_cfg))
        else $error("stored pin setup lost during error");
    a_pause_follows: assert property (@(posedge clk) disable iff (srst)
        !srst |=> ctrl.seq_pause == $past(err_hold))
        else $error("sequencing pause wrong");
    a_analog_follows: assert property (@(posedge clk) disable iff (srst)
        (!srst && !err_hold) |=> analog_sel == ~$past(func_cfg))
        else $error("analog select wrong");

    ////////////////////////////////////////////////////////////////////////
    // Pin drive checks
    a_no_drive_high_od: assert property (@(posedge clk) disable iff (srst)
        (pad_oe[0] && pad_out[0]) |-> $past(drv_cfg[0]))
        else $error("open drain drove high");
    a_unused_no_drive: assert property (@(posedge clk) disable iff (srst)
        (!eff_func[1] || !dir_cfg[1]) |=> !pad_oe[1])
        else $error("pin driven while not an output");
    a_push_pull_drive: assert property (@(posedge clk) disable iff (srst)
        (eff_func[0] && dir_cfg[0] && drv_cfg[0]) |=> (pad_oe[0] && pad_out[0] == $past(out_cfg[0])))
        else $error("push pull output wrong");
    a_od_drive_low: assert property (@(posedge clk) disable iff (srst)
        (eff_func[1] && dir_cfg[1] && !drv_cfg[1] && !out_cfg[1]) |=> (pad_oe[1] && !pad_out[1]))
        else $error("open drain did not pull low");
    a_od_release: assert property (@(posedge clk) disable iff (srst)
        (eff_func[1] && dir_cfg[1] && !drv_cfg[1] && out_cfg[1]) |=> !pad_oe[1])
        else $error("open drain did not release");
endmodule

// *** test/amg_pad_model.sv ***
/*
 Pin-side model: external pull-ups plus an optional outside driver per pin.
 Assumes pad_oe high means the device drives the pin.
*/
`timescale 1ns/1ns
module amg_pad_model (
    // Device side
    input wire logic [7:0] pad_out,
    input wire logic [7:0] pad_oe,
    // Outside driver
    input wire logic [7:0] ext_val,
    input wire logic [7:0] ext_en,
    // Resolved levels
    output logic [7:0] pad_in
);
    // Device drive wins, then outside driver, else pull-up to 1
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            pad_in[i] = pad_oe[i] ? pad_out[i] : (ext_en[i] ? ext_val[i] : 1'b1);
        end
    end
endmodule

// *** test/tb_top.sv ***
/*
 Self-checking bench for the mode and pin register bank.
 Assumes a one-cycle strobe register port and registered outputs.
*/
`timescale 1ns/1ns
module tb_top;
    logic clk = 1'b0;
    logic srst = 1'b1;
    amg_pkg::amg_req_t req = '0;
    logic crc_err_in = 1'b0;
    logic [7:0] ext_val = 8'h00;
    logic [7:0] ext_en = 8'h00;
    logic [7:0] rdata, analog_sel, pad_in, pad_out, pad_oe;
    logic rvalid;
    amg_pkg::amg_ctrl_t ctrl;
    int mismatches = 0;
    int num_checks = 0;
    int cyc = 0;

    ////////////////////////////////////////////////////////////////
    // Clock and instances
    always #2 clk = ~clk;
    amg_regs i_amg_regs (.clk(clk), .srst(srst), .req(req), .rdata(rdata), .rvalid(rvalid),
        .crc_err_in(crc_err_in), .ctrl(ctrl), .analog_sel(analog_sel), .pad_in(pad_in),
        .pad_out(pad_out), .pad_oe(pad_oe));
    amg_pad_model i_amg_pad_model (.pad_out(pad_out), .pad_oe(pad_oe), .ext_val(ext_val),
        .ext_en(ext_en), .pad_in(pad_in));

    ////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= {1'b1, 1'b0, a, d};
        @(posedge clk);
        req <= '0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        req <= {1'b0, 1'b1, a, 8'h00};
        @(posedge clk);
        req <= '0;
        #1;
        chk("rvalid", {8'h00, rvalid}, 9'h001);
        chk("rdata", {1'b0, rdata}, {1'b0, exp});
    endtask
    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset();
        logic [7:0] addrs [6];
        addrs = '{amg_pkg::ADDR_AVG, amg_pkg::ADDR_MODE, amg_pkg::ADDR_FUNC, amg_pkg::ADDR_DIR, amg_pkg::ADDR_DRV,
            amg_pkg::ADDR_OUT};
        foreach (addrs[i])
            rd(addrs[i], 8'h00);
        chk("ctrl", {3'h0, ctrl.auto_mode, ctrl.osc_low_power, ctrl.clk_div}, 9'h000);
        chk("pad_oe", {1'b0, pad_oe}, 9'h000);
        $display("reset test done");
    endtask
    task automatic t_avg();
        for (int n = 0; n < 8; n++)
        begin
            wr(8'h03, 8'hf8 | 8'(n));
            rd(8'h03, 8'(n));
            settle();
            chk("avg_count", ctrl.avg_count, 9'h001 << n);
        end
        $display("averaging test done");
    endtask
    task automatic t_mode();
        wr(8'h04, 8'h3a);
        settle();
        chk("mode", {5'h00, ctrl.auto_mode, ctrl.manual_mode, ctrl.seq_pause, 1'b0}, 9'h008);
        chk("osc", {8'h00, ctrl.osc_low_power}, 9'h001);
        chk("div", {5'h00, ctrl.clk_div}, 9'h00a);
        wr(8'h04, 8'h40);
        settle();
        chk("reserved", {7'h00, ctrl.auto_mode, ctrl.manual_mode}, 9'h000);
        wr(8'h04, 8'h00);
        settle();
        chk("manual", {7'h00, ctrl.auto_mode, ctrl.manual_mode}, 9'h001);
        $display("mode test done");
    endtask
    task automatic t_pins();
        wr(8'h05, 8'h0f);
        wr(8'h07, 8'h13);
        wr(8'h09, 8'h01);
        wr(8'h0b, 8'h13);
        settle();
        chk("analog_sel", {1'b0, analog_sel}, 9'h0f0);
        chk("pad_oe", {1'b0, pad_oe}, 9'h001);
        chk("pad_out0", {8'h00, pad_out[0]}, 9'h001);
        wr(8'h0b, 8'h00);
        settle();
        chk("pad_oe", {1'b0, pad_oe}, 9'h003);
        chk("pad_out", {7'h00, pad_out[1:0]}, 9'h000);
        @(posedge clk);
        ext_en <= 8'h0c;
        ext_val <= 8'h08;
        wr(8'h0d, 8'h55);
        settle();
        rd(8'h0d, 8'hf8);
        $display("pin test done");
    endtask
    task automatic t_crc();
        @(posedge clk);
        crc_err_in <= 1'b1;
        settle();
        chk("keep", {ctrl.seq_pause, analog_sel}, 9'h0f0);
        chk("keep pads", {1'b0, pad_oe}, 9'h003);
        wr(8'h04, 8'h80);
        settle();
        chk("force", {ctrl.seq_pause, analog_sel}, 9'h1ff);
        chk("release", {1'b0, pad_oe}, 9'h000);
        rd(8'h05, 8'h0f);
        @(posedge clk);
        crc_err_in <= 1'b0;
        settle();
        chk("resume", {ctrl.seq_pause, analog_sel}, 9'h0f0);
        chk("restore", {1'b0, pad_oe}, 9'h003);
        $display("checksum error test done");
    endtask
    task automatic t_rerst();
        wr(8'h04, 8'h3a);
        wr(8'h0b, 8'hff);
        @(posedge clk);
        srst <= 1'b1;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        t_reset();
    endtask

    ////////////////////////////////////////////////////////////////
    // Timeout watchdog
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            mismatches++;
            finish_test();
        end
    end

    // Main sequence
    initial
    begin
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_avg();
        t_mode();
        t_pins();
        t_crc();
        t_rerst();
        finish_test();
    end
endmodule
